// file: cie_pkg.sv
package cie_pkg;

	// data path and address widths
	localparam int PC_W    = 15;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 7;
	localparam int INSTR_W = 14;
	localparam int IMM_W   = 11;
	localparam int PAGE_W  = 7;

	// operand fields inside the instruction word
	localparam int FADDR_LSB = 0;
	localparam int DEST_BIT  = 7;
	localparam int LIT_LSB   = 0;
	localparam int IMM_LSB   = 0;

	// page latch slices that feed the upper program counter
	localparam int BR_PAGE_MSB = 6;   // page bits 6:3 -> pc 14:11
	localparam int BR_PAGE_LSB = 3;
	localparam int CW_PAGE_MSB = 6;   // page bits 6:0 -> pc 14:8
	localparam int CW_PAGE_LSB = 0;

	// reset values and increment steps
	localparam logic [PC_W-1:0]   PC_RST   = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
	localparam logic [PC_W-1:0]   PC_STEP  = 15'h0001;

	// watchdog: prescaler and counter widths, counts are arbitrary defaults
	localparam int WDT_PRE_W = 5;
	localparam int WDT_CNT_W = 8;
	localparam logic [WDT_PRE_W-1:0] WDT_PRE_ZERO = 5'h00;
	localparam logic [WDT_PRE_W-1:0] WDT_PRE_LAST = 5'h1f;
	localparam logic [WDT_CNT_W-1:0] WDT_CNT_ZERO = 8'h00;
	localparam logic [WDT_CNT_W-1:0] WDT_CNT_LAST = 8'hff;

	// opcode match and mask pairs
	localparam logic [INSTR_W-1:0] M_CALL   = 14'h3800;
	localparam logic [INSTR_W-1:0] P_CALL   = 14'h2000;
	localparam logic [INSTR_W-1:0] P_BRANCH = 14'h2800;
	localparam logic [INSTR_W-1:0] P_ORLIT  = 14'h3800;
	localparam logic [INSTR_W-1:0] M_FULL   = 14'h3fff;
	localparam logic [INSTR_W-1:0] P_CALL_VIA_WORKING  = 14'h000a;
	localparam logic [INSTR_W-1:0] P_WDTCLR = 14'h0064;
	localparam logic [INSTR_W-1:0] M_BYTE   = 14'h3f00;
	localparam logic [INSTR_W-1:0] P_COMPLEMENT_FILE_OP   = 14'h0900;
	localparam logic [INSTR_W-1:0] P_DECREMENT_FILE_OP   = 14'h0300;
	localparam logic [INSTR_W-1:0] P_DECREMENT_SKIP_ZERO_OP = 14'h0b00;
	localparam logic [INSTR_W-1:0] P_INCREMENT_SKIP_ZERO_OP = 14'h0f00;
	localparam logic [INSTR_W-1:0] P_INCREMENT_FILE_OP   = 14'h0a00;
	localparam logic [INSTR_W-1:0] P_OR_FILE_OP  = 14'h0400;
	localparam logic [INSTR_W-1:0] M_CLEAR_FILE_OP   = 14'h3f80;
	localparam logic [INSTR_W-1:0] P_CLEAR_FILE_OP   = 14'h0180;
	localparam logic [INSTR_W-1:0] M_CLEAR_WORKING_OP   = 14'h3ffc;
	localparam logic [INSTR_W-1:0] P_CLEAR_WORKING_OP   = 14'h0100;

	// execute sequencer states
	typedef enum logic [1:0] {
		ST_EXEC  = 2'b01,
		ST_STALL = 2'b10
	} cie_state_e;

endpackage

// file: cie_core_exec.sv
`timescale 1ns/1ns
// What this block does
// - a direct call pushes the next address, loads the 11-bit immediate into pc 10:0 and page latch 6:3 into pc 14:11, over two cycles.
// - a call through working pushes the next address, loads working into pc 7:0 and page latch 6:0 into pc 14:8, over two cycles.
// - the watchdog clear zeroes the watchdog counter and its prescaler and sets the timeout and power-down flags to one.
// - complement inverts the file register and stores it in working for d=0 or in the file for d=1, updating zero.
// - clear-file writes zero into the addressed file register (address 0 to 127) and sets the zero flag.
// - clear-working writes zero into working and sets the zero flag.
// - decrement subtracts one from the file register, stores it per d and updates zero.
// - decrement-and-skip stores the decrement per d with no flag change and turns the next instruction into a no-op when zero.
// - the branch loads its 11-bit immediate into pc 10:0 and page latch 6:3 into pc 14:11 over two cycles with no flag change.
// - increment-and-skip stores the increment per d with no flag change and turns the next instruction into a no-op when zero.
// - or-literal ors working with an 8-bit literal into working and updates zero.
// - or-with-file ors working with the file register, stores per d and updates zero.
module cie_core_exec (
	input  wire logic                         mclk,
	input  wire logic                         rst,
	input  wire logic                         instr_valid,
	input  wire logic [cie_pkg::INSTR_W-1:0]  instr,
	input  wire logic [cie_pkg::DATA_W-1:0]   file_rdata,
	input  wire logic [cie_pkg::PAGE_W-1:0]   program_page_latch,
	input  wire logic                         wdt_enable,
	input  wire logic                         wdt_tick,
	input  wire logic                         sleep_entry,
	output logic                              instr_ready,
	output logic [cie_pkg::PC_W-1:0]          pc,
	output logic                              stack_push,
	output logic [cie_pkg::PC_W-1:0]          return_stack_top,
	output logic                              file_we,
	output logic [cie_pkg::FADDR_W-1:0]       file_addr,
	output logic [cie_pkg::DATA_W-1:0]        file_wdata,
	output logic [cie_pkg::DATA_W-1:0]        working,
	output logic                              zero_flag,
	output logic                              timeout_flag,
	output logic                              power_down_flag,
	output logic                              wdt_reset_req,
	output logic                              nop_slot
);

	cie_pkg::cie_state_e state;
	cie_pkg::cie_state_e next_state;

	logic                         take;
	logic                         skip_pending;
	logic [cie_pkg::FADDR_W-1:0]  f_sel;
	logic                         dest_file;
	logic [cie_pkg::DATA_W-1:0]   literal;
	logic [cie_pkg::IMM_W-1:0]    imm;
	logic [cie_pkg::PC_W-1:0]     pc_inc;
	logic [cie_pkg::DATA_W-1:0]   f_inc;
	logic [cie_pkg::DATA_W-1:0]   f_dec;

	logic op_call;
	logic op_branch;
	logic op_call_via_working;
	logic op_wdtclr;
	logic op_complement_file_op;
	logic op_clear_file_op;
	logic op_clear_working_op;
	logic op_decrement_file_op;
	logic op_decrement_skip_zero_op;
	logic op_increment_skip_zero_op;
	logic op_increment_file_op;
	logic op_orlit;
	logic op_orwf;

	logic                         exec_op;
	logic                         two_cycle;
	logic                         has_result;
	logic                         upd_zero;
	logic                         next_skip;
	logic [cie_pkg::DATA_W-1:0]   result;
	logic [cie_pkg::PC_W-1:0]     next_pc;
	logic [cie_pkg::WDT_PRE_W-1:0] wdt_pre;
	logic [cie_pkg::WDT_CNT_W-1:0] wdt_cnt;
	logic                         wdt_expire;

	// operand fields and simple arithmetic
	assign take      = instr_valid && instr_ready && (state == cie_pkg::ST_EXEC);
	assign exec_op   = take && !skip_pending;
	assign f_sel     = instr[cie_pkg::FADDR_LSB +: cie_pkg::FADDR_W];
	assign dest_file = instr[cie_pkg::DEST_BIT];
	assign literal   = instr[cie_pkg::LIT_LSB +: cie_pkg::DATA_W];
	assign imm       = instr[cie_pkg::IMM_LSB +: cie_pkg::IMM_W];
	assign pc_inc    = cie_pkg::PC_W'(pc + cie_pkg::PC_STEP);
	assign f_inc     = cie_pkg::DATA_W'(file_rdata + cie_pkg::DATA_ONE);
	assign f_dec     = cie_pkg::DATA_W'(file_rdata - cie_pkg::DATA_ONE);

	// opcode decode by mask and match
	always_comb begin
		op_call   = (instr & cie_pkg::M_CALL) == cie_pkg::P_CALL;
		op_branch = (instr & cie_pkg::M_CALL) == cie_pkg::P_BRANCH;
		op_orlit  = (instr & cie_pkg::M_BYTE) == cie_pkg::P_ORLIT;
		op_call_via_working  = (instr & cie_pkg::M_FULL) == cie_pkg::P_CALL_VIA_WORKING;
		op_wdtclr = (instr & cie_pkg::M_FULL) == cie_pkg::P_WDTCLR;
		op_complement_file_op   = (instr & cie_pkg::M_BYTE) == cie_pkg::P_COMPLEMENT_FILE_OP;
		op_decrement_file_op   = (instr & cie_pkg::M_BYTE) == cie_pkg::P_DECREMENT_FILE_OP;
		op_decrement_skip_zero_op = (instr & cie_pkg::M_BYTE) == cie_pkg::P_DECREMENT_SKIP_ZERO_OP;
		op_increment_skip_zero_op = (instr & cie_pkg::M_BYTE) == cie_pkg::P_INCREMENT_SKIP_ZERO_OP;
		op_increment_file_op   = (instr & cie_pkg::M_BYTE) == cie_pkg::P_INCREMENT_FILE_OP;
		op_orwf   = (instr & cie_pkg::M_BYTE) == cie_pkg::P_OR_FILE_OP;
		op_clear_file_op   = (instr & cie_pkg::M_CLEAR_FILE_OP) == cie_pkg::P_CLEAR_FILE_OP;
		op_clear_working_op   = (instr & cie_pkg::M_CLEAR_WORKING_OP) == cie_pkg::P_CLEAR_WORKING_OP;
	end

	// result, destination and flag selection
	always_comb begin
		result     = cie_pkg::DATA_ZERO;
		has_result = 1'b0;
		upd_zero   = 1'b0;
		next_skip  = 1'b0;
		if (op_complement_file_op) begin
			result     = ~file_rdata;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end else if (op_clear_file_op) begin
			result     = cie_pkg::DATA_ZERO;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end else if (op_clear_working_op) begin
			result     = cie_pkg::DATA_ZERO;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end else if (op_decrement_file_op) begin
			result     = f_dec;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end else if (op_decrement_skip_zero_op) begin
			result     = f_dec;
			has_result = 1'b1;
			next_skip  = (f_dec == cie_pkg::DATA_ZERO);
		end else if (op_increment_skip_zero_op) begin
			result     = f_inc;
			has_result = 1'b1;
			next_skip  = (f_inc == cie_pkg::DATA_ZERO);
		end else if (op_increment_file_op) begin
			result     = f_inc;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end else if (op_orlit) begin
			result     = working | literal;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end else if (op_orwf) begin
			result     = working | file_rdata;
			has_result = 1'b1;
			upd_zero   = 1'b1;
		end
	end

	// program counter target and two-cycle classification
	always_comb begin
		next_pc   = pc_inc;
		two_cycle = 1'b0;
		if (op_call) begin
			next_pc   = {program_page_latch[cie_pkg::BR_PAGE_MSB:
					cie_pkg::BR_PAGE_LSB], imm};
			two_cycle = 1'b1;
		end else if (op_branch) begin
			next_pc   = {program_page_latch[cie_pkg::BR_PAGE_MSB:
					cie_pkg::BR_PAGE_LSB], imm};
			two_cycle = 1'b1;
		end else if (op_call_via_working) begin
			next_pc   = {program_page_latch[cie_pkg::CW_PAGE_MSB:
					cie_pkg::CW_PAGE_LSB], working};
			two_cycle = 1'b1;
		end
	end

	// sequencer: two-cycle ops hold off the next fetch one cycle
	always_comb begin
		case (state)
			cie_pkg::ST_EXEC: begin
				if (exec_op && two_cycle) begin
					next_state = cie_pkg::ST_STALL;
				end else begin
					next_state = cie_pkg::ST_EXEC;
				end
			end
			cie_pkg::ST_STALL: next_state = cie_pkg::ST_EXEC;
			default:           next_state = cie_pkg::ST_EXEC;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state       <= cie_pkg::ST_EXEC;
			instr_ready <= 1'b1;
		end else begin
			state       <= next_state;
			instr_ready <= (next_state == cie_pkg::ST_EXEC);
		end
	end

	// program counter and return stack push
	always_ff @(posedge mclk) begin
		if (rst) begin
			pc               <= cie_pkg::PC_RST;
			stack_push       <= 1'b0;
			return_stack_top <= cie_pkg::PC_RST;
		end else begin
			stack_push <= exec_op && (op_call || op_call_via_working);
			if (exec_op) begin
				pc <= next_pc;
			end else if (take) begin
				pc <= pc_inc;                         // skipped slot
			end
			if (exec_op && (op_call || op_call_via_working)) begin
				return_stack_top <= pc_inc;
			end
		end
	end

	// skip of the following instruction
	always_ff @(posedge mclk) begin
		if (rst) begin
			skip_pending <= 1'b0;
			nop_slot     <= 1'b0;
		end else begin
			nop_slot <= take && skip_pending;
			if (take) begin
				skip_pending <= exec_op && next_skip;
			end
		end
	end

	// file register write port
	always_ff @(posedge mclk) begin
		if (rst) begin
			file_we    <= 1'b0;
			file_addr  <= {cie_pkg::FADDR_W{1'b0}};
			file_wdata <= cie_pkg::DATA_ZERO;
		end else begin
			file_we <= exec_op && has_result && !op_clear_working_op && !op_orlit
				&& (dest_file || op_clear_file_op);
			if (exec_op && has_result) begin
				file_addr  <= f_sel;
				file_wdata <= result;
			end
		end
	end

	// working register
	always_ff @(posedge mclk) begin
		if (rst) begin
			working <= cie_pkg::DATA_ZERO;
		end else if (exec_op && has_result && !op_clear_file_op
				&& (!dest_file || op_clear_working_op || op_orlit)) begin
			working <= result;
		end
	end

	// zero flag, untouched by skip ops and branches
	always_ff @(posedge mclk) begin
		if (rst) begin
			zero_flag <= 1'b0;
		end else if (exec_op && upd_zero) begin
			zero_flag <= (result == cie_pkg::DATA_ZERO);
		end
	end

	// watchdog prescaler and counter, cleared by the clear op
	assign wdt_expire = wdt_enable && wdt_tick
		&& (wdt_pre == cie_pkg::WDT_PRE_LAST)
		&& (wdt_cnt == cie_pkg::WDT_CNT_LAST);

	always_ff @(posedge mclk) begin
		if (rst) begin
			wdt_pre       <= cie_pkg::WDT_PRE_ZERO;
			wdt_cnt       <= cie_pkg::WDT_CNT_ZERO;
			wdt_reset_req <= 1'b0;
		end else begin
			wdt_reset_req <= wdt_expire && !(exec_op && op_wdtclr);
			if (exec_op && op_wdtclr) begin
				wdt_pre <= cie_pkg::WDT_PRE_ZERO;
				wdt_cnt <= cie_pkg::WDT_CNT_ZERO;
			end else if (wdt_enable && wdt_tick) begin
				wdt_pre <= cie_pkg::WDT_PRE_W'(wdt_pre + 1'b1);
				if (wdt_pre == cie_pkg::WDT_PRE_LAST) begin
					wdt_cnt <= cie_pkg::WDT_CNT_W'(wdt_cnt + 1'b1);
				end
			end
		end
	end

	// status flags: clear op sets both, events drop them
	always_ff @(posedge mclk) begin
		if (rst) begin
			timeout_flag    <= 1'b1;
			power_down_flag <= 1'b1;
		end else if (exec_op && op_wdtclr) begin
			timeout_flag    <= 1'b1;
			power_down_flag <= 1'b1;
		end else begin
			if (wdt_expire) begin
				timeout_flag <= 1'b0;
			end
			if (sleep_entry) begin
				power_down_flag <= 1'b0;
			end
		end
	end

endmodule // cie_core_exec

// file: cie_core_exec_asserts.sv
`timescale 1ns/1ns
// port-level checks on the execute block
module cie_core_exec_asserts (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        instr_valid,
	input wire logic [13:0] instr,
	input wire logic [6:0]  program_page_latch,
	input wire logic        instr_ready,
	input wire logic [14:0] pc,
	input wire logic        stack_push,
	input wire logic [14:0] return_stack_top,
	input wire logic        file_we,
	input wire logic [6:0]  file_addr,
	input wire logic [7:0]  file_wdata,
	input wire logic [7:0]  working,
	input wire logic        zero_flag,
	input wire logic        timeout_flag,
	input wire logic        power_down_flag,
	input wire logic        nop_slot
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// instruction taken this edge, opcode slices
	wire        tk = instr_valid && instr_ready;
	wire [13:0] hi = instr & cie_pkg::M_CALL;
	wire [13:0] by = instr & cie_pkg::M_BYTE;

	property p_call;
		tk && hi == cie_pkg::P_CALL |=> nop_slot || (stack_push &&
			pc == {$past(program_page_latch[6:3]), $past(instr[10:0])} &&
			return_stack_top == $past(pc) + 15'h1);
	endproperty
	a_call: assert property (p_call) else $error("call wrong");

	property p_call_via_working;
		tk && instr == cie_pkg::P_CALL_VIA_WORKING |=> nop_slot || (stack_push &&
			pc == {$past(program_page_latch), $past(working)} &&
			return_stack_top == $past(pc) + 15'h1);
	endproperty
	a_call_via_working: assert property (p_call_via_working) else $error("call_via_working wrong");

	property p_branch;
		tk && hi == cie_pkg::P_BRANCH |=> nop_slot || (!stack_push &&
			pc == {$past(program_page_latch[6:3]), $past(instr[10:0])} &&
			$stable(zero_flag));
	endproperty
	a_branch: assert property (p_branch) else $error("branch wrong");

	property p_push;
		stack_push |-> !instr_ready ##1 (!stack_push && instr_ready);
	endproperty
	a_push: assert property (p_push) else $error("push pulse wrong");

	property p_wdtclr;
		tk && instr == cie_pkg::P_WDTCLR |=> nop_slot ||
			(timeout_flag && power_down_flag);
	endproperty
	a_wdtclr: assert property (p_wdtclr) else $error("wdt clear wrong");

	property p_clear_file_op;
		tk && (instr & cie_pkg::M_CLEAR_FILE_OP) == cie_pkg::P_CLEAR_FILE_OP |=> nop_slot ||
			(file_we && file_wdata == 8'h00 && zero_flag &&
			file_addr == $past(instr[6:0]));
	endproperty
	a_clear_file_op: assert property (p_clear_file_op) else $error("clear_file_op wrong");

	property p_orlit;
		tk && by == cie_pkg::P_ORLIT |=> nop_slot ||
			(working == ($past(working) | $past(instr[7:0])) &&
			zero_flag == (working == 8'h00));
	endproperty
	a_orlit: assert property (p_orlit) else $error("or lit wrong");

	property p_skip;
		nop_slot |-> !file_we && !stack_push && $stable(working) &&
			$stable(zero_flag) && pc == $past(pc) + 15'h1;
	endproperty
	a_skip: assert property (p_skip) else $error("skip slot wrong");
endmodule // cie_core_exec_asserts

// file: cie_partner_model.sv
`timescale 1ns/1ns
// register file and return stack facing the block
module cie_partner_model (
	input  wire logic        mclk,
	input  wire logic [13:0] instr,
	input  wire logic        file_we,
	input  wire logic [6:0]  file_addr,
	input  wire logic [7:0]  file_wdata,
	input  wire logic        stack_push,
	input  wire logic [14:0] return_stack_top,
	output logic      [7:0]  file_rdata,
	output logic      [14:0] stack_last
);
	logic [7:0] regs [128];
	// power-up contents are junk, not zero
	initial begin
		for (int i = 0; i < 128; i++)
			regs[i] = 8'ha5 ^ i[7:0];
	end
	// read follows the operand field in the same cycle
	assign file_rdata = regs[instr[6:0]];
	// writes and pushes land on the edge
	always @(posedge mclk) begin
		if (file_we)
			regs[file_addr] <= file_wdata;
		if (stack_push)
			stack_last <= return_stack_top;
	end
endmodule // cie_partner_model

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic [6:0]  program_page_latch = 7'h00;
	logic        wdt_enable = 1'b0;
	logic        wdt_tick = 1'b0;
	logic        sleep_entry = 1'b0;
	wire  [7:0]  file_rdata, file_wdata, working;
	wire  [14:0] pc, return_stack_top, stack_last;
	wire  [6:0]  file_addr;
	wire         instr_ready, stack_push, file_we, zero_flag;
	wire         timeout_flag, power_down_flag, wdt_reset_req, nop_slot;
	int          checks = 0;
	int          fails = 0;
	logic [14:0] a;

	// clock and parts
	initial forever #5 mclk = ~mclk;
	cie_core_exec cie_core_exec_i (.mclk, .rst, .instr_valid, .instr,
		.file_rdata, .program_page_latch, .wdt_enable, .wdt_tick,
		.sleep_entry, .instr_ready, .pc, .stack_push, .return_stack_top,
		.file_we, .file_addr, .file_wdata, .working, .zero_flag,
		.timeout_flag, .power_down_flag, .wdt_reset_req, .nop_slot);
	cie_partner_model cie_partner_model_i (.mclk, .instr, .file_we,
		.file_addr, .file_wdata, .stack_push, .return_stack_top,
		.file_rdata, .stack_last);

	function automatic logic bad(input logic b);
		checks++;
		return b;
	endfunction
	task automatic err(input string m);
		fails++;
		$display("MISMATCH %0t %s", $time, m);
	endtask
	// one instruction, taken on the second edge
	task automatic ex(input logic [13:0] w, input logic [6:0] pg = 7'h00);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr <= w;
		program_page_latch <= pg;
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask
	task automatic t_ctrl();
		ex(cie_pkg::P_CLEAR_WORKING_OP);
		ex(cie_pkg::P_ORLIT | 14'h003c);
		if (bad(working !== 8'h3c || zero_flag !== 1'b0)) err("orlit");
		a = pc;
		ex(cie_pkg::P_CALL | 14'h0123, 7'h55);
		if (bad(pc !== 15'h5123 || return_stack_top !== a + 15'h1)) err("call");
		a = pc;
		ex(cie_pkg::P_CALL_VIA_WORKING, 7'h2a);
		if (bad(pc !== 15'h2a3c || return_stack_top !== a + 15'h1)) err("call_via_working");
		ex(cie_pkg::P_CLEAR_WORKING_OP);
		ex(cie_pkg::P_BRANCH | 14'h07ff, 7'h7f);
		if (bad(pc !== 15'h7fff || zero_flag !== 1'b1)) err("branch");
		if (bad(stack_last !== a + 15'h1)) err("stack");
	endtask
	task automatic t_file();
		ex(cie_pkg::P_CLEAR_FILE_OP | 14'h007f);
		if (bad(file_addr !== 7'h7f || file_wdata !== 8'h00)) err("clear_file_op");
		ex(cie_pkg::P_DECREMENT_FILE_OP | 14'h00ff);
		if (bad(file_wdata !== 8'hff || zero_flag !== 1'b0)) err("decrement_file_op");
		ex(cie_pkg::P_COMPLEMENT_FILE_OP | 14'h007f);
		if (bad(working !== 8'h00 || zero_flag !== 1'b1)) err("complement_file_op");
		ex(cie_pkg::P_INCREMENT_FILE_OP | 14'h00ff);
		if (bad(file_wdata !== 8'h00 || file_we !== 1'b1)) err("increment_file_op");
		ex(cie_pkg::P_ORLIT | 14'h0081);
		ex(cie_pkg::P_CLEAR_WORKING_OP);
		if (bad(working !== 8'h00 || zero_flag !== 1'b1)) err("clear_working_op");
		ex(cie_pkg::P_ORLIT | 14'h0080);
		ex(cie_pkg::P_OR_FILE_OP | 14'h00ff);
		if (bad(file_wdata !== 8'h80 || zero_flag !== 1'b0)) err("or_file_op");
	endtask
	task automatic t_skip();
		ex(cie_pkg::P_CLEAR_FILE_OP | 14'h0010);
		ex(cie_pkg::P_INCREMENT_FILE_OP | 14'h0090);
		ex(cie_pkg::P_CLEAR_WORKING_OP);
		ex(cie_pkg::P_ORLIT | 14'h0001);
		ex(cie_pkg::P_DECREMENT_SKIP_ZERO_OP | 14'h0090);
		if (bad(file_wdata !== 8'h00 || zero_flag !== 1'b0)) err("dsz");
		ex(cie_pkg::P_ORLIT | 14'h00f0);
		if (bad(nop_slot !== 1'b1 || working !== 8'h01)) err("dsz skip");
		ex(cie_pkg::P_DECREMENT_FILE_OP | 14'h0090);
		ex(cie_pkg::P_INCREMENT_SKIP_ZERO_OP | 14'h0010);
		if (bad(working !== 8'h00 || zero_flag !== 1'b0)) err("isz");
		ex(cie_pkg::P_CLEAR_WORKING_OP);
		if (bad(nop_slot !== 1'b1 || zero_flag !== 1'b0)) err("isz skip");
		ex(cie_pkg::P_DECREMENT_SKIP_ZERO_OP | 14'h0010);
		ex(cie_pkg::P_ORLIT | 14'h0001);
		if (bad(nop_slot !== 1'b0 || working !== 8'hff)) err("no skip");
	endtask
	task automatic t_wdt();
		int n;
		@(posedge mclk);
		wdt_enable <= 1'b1;
		wdt_tick <= 1'b1;
		for (n = 0; n < 9000 && wdt_reset_req !== 1'b1; n++)
			@(posedge mclk) #1;
		if (bad(timeout_flag !== 1'b0)) err("expiry");
		@(posedge mclk);
		sleep_entry <= 1'b1;
		@(posedge mclk);
		sleep_entry <= 1'b0;
		#1;
		if (bad(power_down_flag !== 1'b0)) err("sleep");
		repeat (4000) @(posedge mclk);
		ex(cie_pkg::P_WDTCLR);
		if (bad(timeout_flag !== 1'b1 || power_down_flag !== 1'b1)) err("clr");
		for (n = 0; n < 8000 && wdt_reset_req !== 1'b1; n++)
			@(posedge mclk) #1;
		if (bad(n !== 8000)) err("count kept");
		for (n = 0; n < 400 && wdt_reset_req !== 1'b1; n++)
			@(posedge mclk) #1;
		if (bad(wdt_reset_req !== 1'b1)) err("no restart");
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		#1;
		if (bad(pc !== 15'h0000 || timeout_flag !== 1'b1)) err("reset");
		t_ctrl();
		t_file();
		t_skip();
		t_wdt();
		summarize();
	end
	// hang guard
	initial begin
		#400000;
		fails++;
		summarize();
	end
endmodule // tb_top
bind cie_core_exec cie_core_exec_asserts cie_core_exec_asserts_i (.mclk,
	.rst, .instr_valid, .instr, .program_page_latch, .instr_ready, .pc,
	.stack_push, .return_stack_top, .file_we, .file_addr, .file_wdata,
	.working, .zero_flag, .timeout_flag, .power_down_flag, .nop_slot);
